// *** src/fcpe_encoder.sv ***
`timescale 1ns/1ps
module fcpe_encoder
    import fcpe_pkg::*;
(
    // Fault sources
    fcpe_src_if.enc          src,
    // Result
    output logic [3:0]       code_o,
    output logic             irq_o,
    output logic             any_o
);
    // ----------------------------------------------------------------
    // Fixed order, first hit wins
    // ----------------------------------------------------------------
    always_comb
    begin
        code_o = FCPE_CODE_NONE;
        irq_o  = 1'b0;
        any_o  = 1'b1;
        if (src.hit[0])
        begin
            code_o = {1'b0, src.conv_err};
            irq_o  = 1'b1;
        end
        else if (src.hit[1])
        begin
            code_o = FCPE_CODE_CONV_ZERO;
            irq_o  = 1'b1;
        end
        else if (src.hit[2] || src.hit[3])
        begin
            code_o = FCPE_CODE_SERIAL;
            irq_o  = 1'b1;
        end
        else if (src.hit[4])
        begin
            code_o = FCPE_CODE_POLARITY;
            irq_o  = 1'b1;
        end
        else if (src.hit[5])
            code_o = FCPE_CODE_DONE_WAIT;
        else if (src.hit[6])
            code_o = FCPE_CODE_RAMP;
        else if (src.hit[7])
            code_o = FCPE_CODE_SUPPLY;
        else if (src.hit[8])
        begin
            code_o = FCPE_CODE_SUPPLY;
            irq_o  = 1'b1;
        end
        else
            any_o  = 1'b0;
    end
endmodule : fcpe_encoder

// *** src/fcpe_pkg.sv ***
package fcpe_pkg;

    // ----------------------------------------------------------------
    // Fault codes
    // ----------------------------------------------------------------
    localparam logic [3:0] FCPE_CODE_CONV_ZERO = 4'hc;
    localparam logic [3:0] FCPE_CODE_SERIAL    = 4'hd;
    localparam logic [3:0] FCPE_CODE_POLARITY  = 4'he;
    localparam logic [3:0] FCPE_CODE_DONE_WAIT = 4'h8;
    localparam logic [3:0] FCPE_CODE_RAMP      = 4'h9;
    localparam logic [3:0] FCPE_CODE_SUPPLY    = 4'hb;
    localparam logic [3:0] FCPE_CODE_NONE      = 4'ha;
    localparam logic [2:0] FCPE_CONV_ERR_NONE  = 3'h0;
    localparam logic [3:0] FCPE_CMD_OPEN_ALL   = 4'h0;

    // ----------------------------------------------------------------
    // Serial framing
    // ----------------------------------------------------------------
    localparam logic [3:0] FCPE_SCLK_LIMIT     = 4'h9;
    localparam logic [3:0] FCPE_IRQ_CLR_EDGE   = 4'h5;
    localparam int         FCPE_NUM_SRC        = 9;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] FCPE_CODE_RST       = FCPE_CODE_NONE;

endpackage : fcpe_pkg

// *** src/fcpe_src_if.sv ***
`timescale 1ns/1ps
interface fcpe_src_if;
    import fcpe_pkg::*;
    logic [FCPE_NUM_SRC-1:0] hit;
    logic [2:0]              conv_err;
    modport src (output hit, output conv_err);
    modport enc (input hit, input conv_err);
endinterface : fcpe_src_if

// *** src/fcpe_top.sv ***
// Operation
// - Report only highest priority pending fault
// - Converter fault nonzero: code 0,err; interrupt
// - Converter fault zero error: 1100, interrupt
// - Serial input high when low: 1101, interrupt
// - Polarity echo not inverse: 1110, interrupt
// - Select during done wait: 1000, no interrupt
// - Select during ramp low/wait: 1001, no interrupt
// - Select, supply low, not open-all: 1011
// - Supply drop after good while active raises interrupt
// - Ninth serial clock edge is fault, interrupt
// - Reading the code clears stored fault
// - Drop interrupt between fourth and sixth edges
`timescale 1ns/1ps
module fcpe_top
    import fcpe_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Converter
    input  wire logic        conv_en_i,
    input  wire logic        conv_done_i,
    input  wire logic [2:0]  conv_err_i,
    input  wire logic        polarity_req_i,
    input  wire logic        polarity_echo_i,
    // Serial port
    input  wire logic        cs_n_i,
    input  wire logic        sclk_i,
    input  wire logic        sdi_i,
    input  wire logic        sdi_must_low_i,
    // Sequencer state
    input  wire logic        wait_done_i,
    input  wire logic        ramp_flag_i,
    input  wire logic        wait_ramp_i,
    input  wire logic        supply_ok_flag_i,
    input  wire logic        active_i,
    input  wire logic [3:0]  cmd_i,
    // Fault report
    output logic [3:0]       fault_code_o,
    output logic             fault_irq_o,
    output logic             fault_pend_o
);
    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    logic       done_reg, sclk_reg, cs_n_reg, ok_reg, ok_seen_reg;
    logic [3:0] edge_cnt_reg, edge_cnt_next;
    logic [FCPE_NUM_SRC-1:0] hold_reg, hold_next;
    logic [3:0] code_reg;
    logic       irq_reg, pend_reg;
    logic [2:0] err_hold_reg;
    logic       fall_reg;
    wire        done_rise = conv_done_i && !done_reg;
    wire        sclk_rise = sclk_i && !sclk_reg && !cs_n_i;
    wire        cs_fall   = !cs_n_i && cs_n_reg;
    wire        in_xfer   = !cs_n_i;
    wire        ok_fall   = !supply_ok_flag_i && ok_reg && ok_seen_reg;
    wire        read_done = cs_n_i && !cs_n_reg;
    wire [FCPE_NUM_SRC-1:0] ev;
    wire        irq_set   = |(ev & 9'h11f);
    wire [3:0]  enc_code;
    wire        enc_irq, enc_any;
    fcpe_src_if src_bus ();

    // Converter faults are masked during serial transactions
    assign ev[0] = done_rise && conv_en_i && !in_xfer
                   && conv_err_i != FCPE_CONV_ERR_NONE;
    assign ev[1] = done_rise && conv_en_i && !in_xfer
                   && conv_err_i == FCPE_CONV_ERR_NONE;
    assign ev[2] = sclk_rise && sdi_i && sdi_must_low_i;
    assign ev[3] = sclk_rise && edge_cnt_reg == FCPE_SCLK_LIMIT - 4'h1;
    assign ev[4] = polarity_echo_i == polarity_req_i && !in_xfer;
    assign ev[5] = cs_fall && wait_done_i;
    assign ev[6] = cs_fall && (!ramp_flag_i || wait_ramp_i);
    assign ev[7] = cs_fall && !supply_ok_flag_i && cmd_i != FCPE_CMD_OPEN_ALL;
    assign ev[8] = ok_fall && active_i;

    // Set wins over the clear so a fault on the read edge survives
    assign hold_next = (read_done ? '0 : hold_reg) | ev;
    assign edge_cnt_next = cs_n_i ? 4'h0
                         : (sclk_rise && edge_cnt_reg != 4'hf) ? edge_cnt_reg + 4'h1
                         : edge_cnt_reg;
    assign src_bus.hit      = hold_reg;
    // Converter code pins are only valid around done, so the code is kept from the event
    assign src_bus.conv_err = err_hold_reg;

    fcpe_encoder u_enc
    (
        .src    (src_bus.enc),
        .code_o (enc_code),
        .irq_o  (enc_irq),
        .any_o  (enc_any)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            done_reg     <= 1'b0;
            sclk_reg     <= 1'b0;
            cs_n_reg     <= 1'b1;
            ok_reg       <= 1'b0;
            ok_seen_reg  <= 1'b0;
            edge_cnt_reg <= 4'h0;
            hold_reg     <= '0;
            err_hold_reg <= FCPE_CONV_ERR_NONE;
            fall_reg     <= 1'b0;
        end
        else
        begin
            done_reg     <= conv_done_i;
            sclk_reg     <= sclk_i;
            cs_n_reg     <= cs_n_i;
            ok_reg       <= supply_ok_flag_i;
            ok_seen_reg  <= ok_seen_reg | supply_ok_flag_i;
            edge_cnt_reg <= edge_cnt_next;
            hold_reg     <= hold_next;
            fall_reg     <= cs_fall;
            if (ev[0])
                err_hold_reg <= conv_err_i;
        end
    end

    // Code is taken one cycle after select falls, so faults raised at the fall go out
    // in this frame; then frozen. The host must allow two clocks before shifting
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            code_reg <= FCPE_CODE_RST;
            irq_reg  <= 1'b0;
            pend_reg <= 1'b0;
        end
        else
        begin
            if (cs_n_i || fall_reg)
                code_reg <= enc_code;
            pend_reg <= enc_any;
            // Set wins so a fault on the clearing edge is not lost
            if (irq_set)
                irq_reg <= 1'b1;
            else if (sclk_rise && edge_cnt_reg == FCPE_IRQ_CLR_EDGE - 4'h1)
                irq_reg <= 1'b0;
        end
    end

    assign fault_code_o = code_reg;
    assign fault_irq_o  = irq_reg;
    assign fault_pend_o = pend_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_fifth_edge;
        sclk_rise && edge_cnt_reg == FCPE_IRQ_CLR_EDGE - 4'h1 && !irq_set;
    endsequence
    property p_irq_clear;
        @(posedge ref_clk_i) disable iff (rst_i) s_fifth_edge |=> !fault_irq_o;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
    property p_idle_code;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cs_n_i && hold_reg == '0) |=> fault_code_o == 4'ha;
    endproperty
    a_idle_code: assert property (p_idle_code) else $error("bad idle code");
    property p_conv;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cs_n_i && ev[0]) |=> ##1 (fault_code_o == {1'b0, $past(conv_err_i, 2)} && fault_irq_o);
    endproperty
    a_conv: assert property (p_conv) else $error("converter code wrong");
    property p_zero;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cs_n_i && ev[1]) |=> ##1 (fault_code_o == 4'hc && fault_irq_o);
    endproperty
    a_zero: assert property (p_zero) else $error("zero-error code wrong");
    property p_pol;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cs_n_i && ev[4] && !(|ev[3:0]) && !(|hold_reg[3:0])) |=> ##1 fault_code_o == 4'he;
    endproperty
    a_pol: assert property (p_pol) else $error("polarity code wrong");
    property p_ninth;
        @(posedge ref_clk_i) disable iff (rst_i) ev[3] |=> fault_irq_o && hold_reg[3];
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth edge missed");
    property p_noirq;
        @(posedge ref_clk_i) disable iff (rst_i)
        (!fault_irq_o && (|ev[7:5]) && !(|(ev & 9'h11f))) |=> !fault_irq_o;
    endproperty
    a_noirq: assert property (p_noirq) else $error("irq raised wrongly");
    property p_clear;
        @(posedge ref_clk_i) disable iff (rst_i) (read_done && ev == '0) |=> hold_reg == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("read did not clear");
    property p_supply;
        @(posedge ref_clk_i) disable iff (rst_i) ev[8] |=> fault_irq_o;
    endproperty
    a_supply: assert property (p_supply) else $error("supply drop missed");
    // Codes raised at select fall are taken one cycle later, before any shift
    sequence s_taken;
        fall_reg;
    endsequence
    property p_wait_code;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_taken ##0 (!(|hold_reg[4:0]) && hold_reg[5])
        |=> fault_code_o == FCPE_CODE_DONE_WAIT;
    endproperty
    a_wait_code: assert property (p_wait_code) else $error("wait code not shown");
    property p_ramp_code;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_taken ##0 (!(|hold_reg[5:0]) && hold_reg[6]) |=> fault_code_o == FCPE_CODE_RAMP;
    endproperty
    a_ramp_code: assert property (p_ramp_code) else $error("ramp code not shown");
    property p_supply_code;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_taken ##0 (!(|hold_reg[6:0]) && hold_reg[7]) |=> fault_code_o == FCPE_CODE_SUPPLY;
    endproperty
    a_supply_code: assert property (p_supply_code) else $error("supply code missing");
    property p_irq_agree;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_taken ##0 enc_irq |-> fault_irq_o;
    endproperty
    a_irq_agree: assert property (p_irq_agree) else $error("held fault lost irq");
endmodule : fcpe_top

// *** tb/fcpe_conv_model.sv ***
`timescale 1ns/1ps
module fcpe_conv_model
(
    // Clock and bench commands
    input  wire logic       ref_clk_i,
    input  wire logic       fire_i,
    input  wire logic [2:0] fire_err_i,
    input  wire logic       bad_echo_i,
    // Converter pins
    input  wire logic       polarity_req_i,
    output logic            done_o,
    output logic [2:0]      err_o,
    output logic            echo_o
);
    // ----------------------------------------------------------------
    // Converter behaviour
    // ----------------------------------------------------------------
    logic [2:0] walk_reg = 3'h5;
    // Code is only valid with done high; it walks otherwise so no stale value passes
    always @(negedge ref_clk_i)
        walk_reg <= ~walk_reg + 3'h1;
    assign done_o = fire_i;
    assign err_o  = fire_i ? fire_err_i : walk_reg;
    // Echo is the inverse of the request unless a scenario asks for a wrong one
    assign echo_o = ~polarity_req_i ^ bad_echo_i;
endmodule : fcpe_conv_model

// *** tb/test_fault_code_priority_encoder.sv ***
`timescale 1ns/1ps
module test_fault_code_priority_encoder;
    import fcpe_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        ref_clk_i, rst_i, conv_en_i, polarity_req_i, cs_n_i, sclk_i, sdi_i;
    logic        sdi_must_low_i, wait_done_i, ramp_flag_i, wait_ramp_i, supply_ok_flag_i;
    logic        active_i, fire, bad_echo, done, echo, fault_irq_o, fault_pend_o;
    logic [2:0]  err, fire_err;
    logic [3:0]  cmd_i, fault_code_o;
    logic [31:0] seed_reg = 32'h0a955b40;
    int          bad_count = 0, n_compared = 0, cyc = 0;
    logic [3:0]  cs_code [5] = '{FCPE_CODE_DONE_WAIT, FCPE_CODE_RAMP, FCPE_CODE_RAMP,
                                 FCPE_CODE_SUPPLY, FCPE_CODE_NONE};

    fcpe_conv_model conv_u (.ref_clk_i, .fire_i(fire), .fire_err_i(fire_err),
        .bad_echo_i(bad_echo), .polarity_req_i, .done_o(done), .err_o(err), .echo_o(echo));
    fcpe_top dut_u (.ref_clk_i, .rst_i, .conv_en_i, .conv_done_i(done), .conv_err_i(err),
        .polarity_req_i, .polarity_echo_i(echo), .cs_n_i, .sclk_i, .sdi_i, .sdi_must_low_i,
        .wait_done_i, .ramp_flag_i, .wait_ramp_i, .supply_ok_flag_i, .active_i, .cmd_i,
        .fault_code_o, .fault_irq_o, .fault_pend_o);

    initial
    begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] conv_code(input logic [2:0] e);
        return (e == FCPE_CONV_ERR_NONE) ? FCPE_CODE_CONV_ZERO : {1'b0, e};
    endfunction : conv_code
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : tick
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic randomise();
        seed_reg = seed_reg ^ (seed_reg << 13);
        seed_reg = seed_reg ^ (seed_reg >> 17);
        seed_reg = seed_reg ^ (seed_reg << 5);
        polarity_req_i = seed_reg[0];
        cmd_i = seed_reg[7:4] | 4'h1;
    endtask : randomise
    // A read: code is checked three clocks after select falls, before the first shift, so faults raised at select fall show
    task automatic read_out(input int n, input logic [3:0] code, input logic irq0,
                            input logic bad);
        cs_n_i = 1'b0;
        tick(3);
        chk(fault_code_o, code);
        for (int i = 1; i <= n; i++)
        begin
            sdi_i = bad && (i == 2);
            sclk_i = 1'b1;
            tick(2);
            {sclk_i, sdi_i} = 2'h0;
            tick(2);
            if (i == 2 && bad)
                chk({3'h0, fault_irq_o}, 4'h1);
            if (i == 3)
                chk({3'h0, fault_irq_o}, {3'h0, irq0 | bad});
            if (i == 6)
                chk({3'h0, fault_irq_o}, 4'h0);
        end
        chk({3'h0, fault_irq_o}, {3'h0, n > 8});
        chk({3'h0, fault_pend_o}, {3'h0, code != FCPE_CODE_NONE || n > 8 || bad});
        cs_n_i = 1'b1;
        tick(4);
        chk(fault_code_o, FCPE_CODE_NONE);
        chk({3'h0, fault_pend_o}, 4'h0);
    endtask : read_out

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        {rst_i, conv_en_i, ramp_flag_i, supply_ok_flag_i, active_i, cs_n_i} = 6'h3f;
        {polarity_req_i, sclk_i, sdi_i, wait_done_i, wait_ramp_i, fire, bad_echo} = 7'h00;
        {sdi_must_low_i, fire_err, cmd_i} = 8'h81;
        tick(20);
        rst_i = 1'b0;
        tick(2);
        chk(fault_code_o, FCPE_CODE_RST);
        chk({2'h0, fault_irq_o, fault_pend_o}, 4'h0);
        for (int k = 0; k < 8; k++)
        begin
            randomise();
            {fire, fire_err, bad_echo} = {1'b1, k[2:0], k == 5};
            tick(1);
            fire = 1'b0;
            tick(3);
            bad_echo = 1'b0;
            chk({3'h0, fault_irq_o}, 4'h1);
            read_out(6 + k % 3, conv_code(k[2:0]), 1'b1, 1'b0);
        end
        bad_echo = 1'b1;
        tick(3);
        bad_echo = 1'b0;
        tick(2);
        read_out(6, FCPE_CODE_POLARITY, 1'b1, 1'b0);
        supply_ok_flag_i = 1'b0;
        tick(3);
        supply_ok_flag_i = 1'b1;
        read_out(6, FCPE_CODE_SUPPLY, 1'b1, 1'b0);
        for (int j = 0; j < 5; j++)
        begin
            randomise();
            {wait_done_i, ramp_flag_i, wait_ramp_i, active_i} = {j == 0, j != 1, j == 2, j < 3};
            tick(1);
            supply_ok_flag_i = (j < 3);
            cmd_i = (j == 4) ? FCPE_CMD_OPEN_ALL : cmd_i;
            tick(2);
            read_out(6, cs_code[j], 1'b0, 1'b0);
            {wait_done_i, wait_ramp_i, ramp_flag_i, supply_ok_flag_i} = 4'h3;
            tick(2);
            active_i = 1'b1;
        end
        read_out(9, FCPE_CODE_NONE, 1'b0, 1'b0);
        read_out(6, FCPE_CODE_NONE, 1'b0, 1'b1);
        complete_run();
    end

    // Hang guard: the sequence needs well under 2000 cycles
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            bad_count++;
            complete_run();
        end
    end
endmodule : test_fault_code_priority_encoder
